// [pkg/pfs_pkg.sv]
package pfs_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_DIR     = 4'h0;  // port1_direction_reg
   localparam logic [3:0] IDX_KEY     = 4'h1;  // key_input_enable_reg
   localparam logic [3:0] IDX_ADSEL   = 4'h2;  // analog_input_select_reg
   localparam logic [3:0] IDX_TRC0    = 4'h3;  // timer_c_pin_select_reg0
   localparam logic [3:0] IDX_TRC1    = 4'h4;  // timer_c_pin_select_reg1
   localparam logic [3:0] IDX_U0SEL   = 4'h5;  // uart0_pin_select_reg
   localparam logic [3:0] IDX_U0MODE  = 4'h6;  // uart0_mode_reg
   localparam logic [3:0] IDX_U0CTL   = 4'h7;  // uart0_control_reg0
   localparam logic [3:0] IDX_TASEL   = 4'h8;  // timer_a_pin_select_reg
   localparam logic [3:0] IDX_TAMODE  = 4'h9;  // timer_a_mode_reg
   localparam logic [3:0] IDX_INTCFG  = 4'hA;  // interrupt1 / comparator bits
   localparam logic [3:0] IDX_PULL    = 4'hB;  // pull-up group bits
   localparam logic [3:0] IDX_DRV0    = 4'hC;  // port0 drive bit
   localparam logic [3:0] IDX_DRV1    = 4'hD;  // port1_drive_reg
   localparam logic [3:0] IDX_TBUSE   = 4'hE;  // timer b output usage
   localparam logic [3:0] IDX_STAT    = 4'hF;  // read-only function status

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CH_LSB   = 0;  // analog_channel_field [2:0]
   localparam int GRP_LSB  = 4;  // analog_group_field [5:4]
   localparam int TRC_A_LSB = 0; // reg0 chan A [2:0]
   localparam int TRC_B_LSB = 4; // reg0 chan B [5:4]
   localparam int TRC_C_LSB = 0; // reg1 chan C [1:0]
   localparam int TRC_D_LSB = 4; // reg1 chan D [6:4]
   localparam int U0_TX_BIT = 0; // uart0_transmit_pin_bit
   localparam int U0_RX_BIT = 2; // uart0_receive_pin_bit
   localparam int U0_CK_BIT = 4; // uart0_clock_pin_bit
   localparam int SMD_LSB   = 0; // serial_mode_field [2:0]
   localparam int CLOCK_DIRECTION_BIT_BIT = 3; // clock_direction_bit
   localparam int NCH_BIT   = 5; // open_drain_select_bit
   localparam int TA_PIN_LSB = 0; // timer_a_io_pin_field [1:0]
   localparam int TA_POL_BIT = 4; // timer_a_polarity_bit
   localparam int TIMER_A_OPERATING_MODE_FIELD_LSB   = 0; // timer_a_operating_mode_field [2:0]
   localparam int I1_PIN_BIT = 0; // interrupt1_pin_bit
   localparam int I1_EN_BIT  = 1; // interrupt1_enable_bit
   localparam int I1_CP_BIT  = 2; // comparator1_input_bit
   localparam int PU_LO_BIT  = 2; // port1_low_pullup_bit
   localparam int PU_HI_BIT  = 3; // port1_high_pullup_bit
   localparam int PU_P07_BIT = 1; // port0 pin 7 group pull-up bit
   localparam int DRV0_BIT   = 1; // port0_drive_bit

   // ---------------------------------------------------------------
   // encodings and reset value
   // ---------------------------------------------------------------
   localparam logic [1:0] GRP_P1     = 2'h1;
   localparam logic [2:0] CH_P1_0    = 3'h0;
   localparam logic [2:0] CH_P1_1    = 3'h1;
   localparam logic [2:0] CH_P1_2    = 3'h2;
   localparam logic [2:0] CH_P1_3    = 3'h3;
   localparam logic [2:0] TRC_D_P10  = 3'h1;
   localparam logic [2:0] TRC_A_P11  = 3'h1;
   localparam logic [1:0] TRC_B_P12  = 2'h1;
   localparam logic [1:0] TRC_C_P13  = 2'h1;
   localparam logic [2:0] SMD_SYNC   = 3'h1;
   localparam logic [1:0] TA_PIN_P15 = 2'h2;
   localparam logic [1:0] TA_PIN_P17 = 2'h1;
   localparam logic [2:0] TIMER_A_OPERATING_MODE_FIELD_LIN_M = 3'h0;
   localparam logic [2:0] TIMER_A_OPERATING_MODE_FIELD_PULSE = 3'h1;
   localparam logic [2:0] TIMER_A_OPERATING_MODE_FIELD_LIN_S = 3'h3;
   localparam logic [7:0] REG_RESET  = 8'h00;

   // drive/pull attributes of one pin
   typedef struct packed {
      logic out;    // output value
      logic oe;     // output enable
      logic pull;   // pull-up enable
      logic hidrv;  // high drive capacity
   } pfs_pad_t;

endpackage

// [hdl/pfs_top.sv]
`timescale 1ns/1ps
// Contract
// - low group pull-up on inputs of pins 0-3
// - high group pull-up on inputs of pins 4-7
// - port0 pin7 drive and pull-up bits
// - per-pin port1 high drive bit
// - pin0 analog when channel selects it
// - pin1 analog when channel 001 group 01
// - pin2 analog when channel 010 group 01
// - pin3 timer B output beats timer C
// - uart0 transmit open-drain by control bit
// - pin6 external uart0 clock input
// - pin6 drives internal uart0 clock out
// - pin6 comparator1 reference input
// - timer A pulse output on selected pin
// - timer A input outside modes 000, 001
// - LIN master shares pin5 receive, timer
// - LIN slave shares pin5 with interrupt1
module pfs_top (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [5:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // port 1 pins
   input  wire logic [7:0]  p1_in,
   output logic      [7:0]  p1_out,
   output logic      [7:0]  p1_oe,
   output logic      [7:0]  p1_pullup,
   output logic      [7:0]  p1_hidrv,
   // port 0 pin 7 attributes
   output logic             p07_pullup,
   output logic             p07_hidrv,
   // peripheral side outputs and routed inputs
   input  wire logic [7:0]  p1_gpio_out,
   input  wire logic        uart0_txd,
   input  wire logic        uart0_clk_out,
   input  wire logic        timer_a_pulse,
   input  wire logic        timer_b_output,
   input  wire logic        timer_c_out_c,
   output logic      [3:0]  analog_en,
   output logic             uart0_rxd,
   output logic             uart0_clk_in,
   output logic             timer_a_in,
   output logic             int1_in,
   output logic             cmp1_ref_en,
   output logic             key_in_en_q
);

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [7:0] dir_q, key_q, adsel_q, trc0_q, trc1_q;  // steering fields
   logic [7:0] u0sel_q, u0mode_q, u0ctl_q, tasel_q;    // uart / timer a
   logic [7:0] tamode_q, intcfg_q, pull_q, drv0_q;     // misc
   logic [7:0] drv1_q, tbuse_q;                        // drive, timer b usage
   logic [7:0] stat_w;                                 // live function status

   // one write strobe, one register updated per cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dir_q    <= pfs_pkg::REG_RESET;
         key_q    <= pfs_pkg::REG_RESET;
         adsel_q  <= pfs_pkg::REG_RESET;
         trc0_q   <= pfs_pkg::REG_RESET;
         trc1_q   <= pfs_pkg::REG_RESET;
         u0sel_q  <= pfs_pkg::REG_RESET;
         u0mode_q <= pfs_pkg::REG_RESET;
         u0ctl_q  <= pfs_pkg::REG_RESET;
         tasel_q  <= pfs_pkg::REG_RESET;
         tamode_q <= pfs_pkg::REG_RESET;
         intcfg_q <= pfs_pkg::REG_RESET;
         pull_q   <= pfs_pkg::REG_RESET;
         drv0_q   <= pfs_pkg::REG_RESET;
         drv1_q   <= pfs_pkg::REG_RESET;
         tbuse_q  <= pfs_pkg::REG_RESET;
      end else if (reg_wr && reg_addr[1:0] == 2'h0) begin
         unique case (reg_addr[5:2])
            pfs_pkg::IDX_DIR:    dir_q    <= reg_wdata;
            pfs_pkg::IDX_KEY:    key_q    <= reg_wdata;
            pfs_pkg::IDX_ADSEL:  adsel_q  <= reg_wdata;
            pfs_pkg::IDX_TRC0:   trc0_q   <= reg_wdata;
            pfs_pkg::IDX_TRC1:   trc1_q   <= reg_wdata;
            pfs_pkg::IDX_U0SEL:  u0sel_q  <= reg_wdata;
            pfs_pkg::IDX_U0MODE: u0mode_q <= reg_wdata;
            pfs_pkg::IDX_U0CTL:  u0ctl_q  <= reg_wdata;
            pfs_pkg::IDX_TASEL:  tasel_q  <= reg_wdata;
            pfs_pkg::IDX_TAMODE: tamode_q <= reg_wdata;
            pfs_pkg::IDX_INTCFG: intcfg_q <= reg_wdata;
            pfs_pkg::IDX_PULL:   pull_q   <= reg_wdata;
            pfs_pkg::IDX_DRV0:   drv0_q   <= reg_wdata;
            pfs_pkg::IDX_DRV1:   drv1_q   <= reg_wdata;
            pfs_pkg::IDX_TBUSE:  tbuse_q  <= reg_wdata;
            default: ;  // status register is read-only
         endcase
      end
   end

   // ---------------------------------------------------------------
   // field extraction
   // ---------------------------------------------------------------
   logic [2:0] ch_f, smd_f, timer_a_operating_mode_field_f, trc_a_f, trc_d_f;
   logic [1:0] grp_f, trc_b_f, trc_c_f, ta_pin_f;
   logic       clock_direction_bit_f, nch_f, tapol_f, i1_pin, i1_en, i1_cp;
   logic       u0_tx, u0_rx, u0_ck;
   assign ch_f     = adsel_q[pfs_pkg::CH_LSB +: 3];
   assign grp_f    = adsel_q[pfs_pkg::GRP_LSB +: 2];
   assign trc_a_f  = trc0_q[pfs_pkg::TRC_A_LSB +: 3];
   assign trc_b_f  = trc0_q[pfs_pkg::TRC_B_LSB +: 2];
   assign trc_c_f  = trc1_q[pfs_pkg::TRC_C_LSB +: 2];
   assign trc_d_f  = trc1_q[pfs_pkg::TRC_D_LSB +: 3];
   assign smd_f    = u0mode_q[pfs_pkg::SMD_LSB +: 3];
   assign clock_direction_bit_f  = u0mode_q[pfs_pkg::CLOCK_DIRECTION_BIT_BIT];
   assign nch_f    = u0ctl_q[pfs_pkg::NCH_BIT];
   assign u0_tx    = u0sel_q[pfs_pkg::U0_TX_BIT];
   assign u0_rx    = u0sel_q[pfs_pkg::U0_RX_BIT];
   assign u0_ck    = u0sel_q[pfs_pkg::U0_CK_BIT];
   assign ta_pin_f = tasel_q[pfs_pkg::TA_PIN_LSB +: 2];
   assign tapol_f  = tasel_q[pfs_pkg::TA_POL_BIT];
   assign timer_a_operating_mode_field_f   = tamode_q[pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_LSB +: 3];
   assign i1_pin   = intcfg_q[pfs_pkg::I1_PIN_BIT];
   assign i1_en    = intcfg_q[pfs_pkg::I1_EN_BIT];
   assign i1_cp    = intcfg_q[pfs_pkg::I1_CP_BIT];

   // ---------------------------------------------------------------
   // function decode
   // ---------------------------------------------------------------
   logic [3:0] an_w;
   logic       tb_out, tc_out, tx_on, ck_out, ck_in, cmp_w;
   logic       ta_p15, ta_p17, ta_pulse, ta_inmode, lin_m, lin_s;
   logic [7:0] in_w;  // pin set to input by its direction bit
   always_comb begin
      // analog routing needs input direction and key input off
      an_w[0] = !dir_q[0] && !key_q[0] && grp_f == pfs_pkg::GRP_P1 &&
                ch_f == pfs_pkg::CH_P1_0 && trc_d_f != pfs_pkg::TRC_D_P10;
      an_w[1] = !dir_q[1] && !key_q[1] && grp_f == pfs_pkg::GRP_P1 &&
                ch_f == pfs_pkg::CH_P1_1 && trc_a_f != pfs_pkg::TRC_A_P11;
      an_w[2] = !dir_q[2] && !key_q[2] && grp_f == pfs_pkg::GRP_P1 &&
                ch_f == pfs_pkg::CH_P1_2 && trc_b_f != pfs_pkg::TRC_B_P12;
      an_w[3] = !dir_q[3] && !key_q[3] && grp_f == pfs_pkg::GRP_P1 &&
                ch_f == pfs_pkg::CH_P1_3 && !tbuse_q[0] &&
                trc_c_f != pfs_pkg::TRC_C_P13;
      // timer b usage wins pin 3 over timer c
      tb_out  = tbuse_q[0];
      tc_out  = !tbuse_q[0] && trc_c_f == pfs_pkg::TRC_C_P13;
      tx_on   = u0_tx;
      // internal clock out ignores direction
      ck_out  = u0_ck && smd_f == pfs_pkg::SMD_SYNC && !clock_direction_bit_f;
      ck_in   = !dir_q[6] && u0_ck && clock_direction_bit_f;
      cmp_w   = !dir_q[6] && !u0_ck && i1_cp;
      ta_p15  = ta_pin_f == pfs_pkg::TA_PIN_P15 && !tapol_f;
      ta_p17  = ta_pin_f == pfs_pkg::TA_PIN_P17 && !tapol_f;
      ta_pulse = timer_a_operating_mode_field_f == pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_PULSE;
      ta_inmode = timer_a_operating_mode_field_f != pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_LIN_M && timer_a_operating_mode_field_f != pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_PULSE;
      lin_m   = u0_rx && ta_p15 && timer_a_operating_mode_field_f == pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_LIN_M;
      lin_s   = u0_rx && ta_p15 && timer_a_operating_mode_field_f == pfs_pkg::TIMER_A_OPERATING_MODE_FIELD_LIN_S &&
                i1_pin && i1_en && !i1_cp;
      in_w    = ~dir_q;
   end

   // ---------------------------------------------------------------
   // pad attributes
   // ---------------------------------------------------------------
   pfs_pkg::pfs_pad_t pad_w [8];
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_w[i].out   = p1_gpio_out[i];
         pad_w[i].oe    = dir_q[i];
         pad_w[i].pull  = in_w[i] &&
                          (i < 4 ? pull_q[pfs_pkg::PU_LO_BIT]
                                 : pull_q[pfs_pkg::PU_HI_BIT]);
         pad_w[i].hidrv = drv1_q[i];
      end
      if (tb_out) begin
         pad_w[3].out = timer_b_output;
         pad_w[3].oe  = 1'b1;
      end else if (tc_out && dir_q[3]) begin
         pad_w[3].out = timer_c_out_c;
      end
      if (tx_on) begin
         // open-drain only pulls low; high is released
         pad_w[4].out = nch_f ? 1'b0 : uart0_txd;
         pad_w[4].oe  = nch_f ? !uart0_txd : 1'b1;
         pad_w[4].pull = 1'b0;
      end
      if (ck_out) begin
         pad_w[6].out  = uart0_clk_out;
         pad_w[6].oe   = 1'b1;
         pad_w[6].pull = 1'b0;
      end
      if (ta_p15 && ta_pulse) begin
         pad_w[5].out  = timer_a_pulse;
         pad_w[5].oe   = 1'b1;
         pad_w[5].pull = 1'b0;
      end
      if (ta_p17 && ta_pulse) begin
         pad_w[7].out  = timer_a_pulse;
         pad_w[7].oe   = 1'b1;
         pad_w[7].pull = 1'b0;
      end
   end

   // registered pad outputs and port0 pin 7 attributes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         p1_out     <= 8'h00;
         p1_oe      <= 8'h00;
         p1_pullup  <= 8'h00;
         p1_hidrv   <= 8'h00;
         p07_pullup <= 1'b0;
         p07_hidrv  <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            p1_out[i]    <= pad_w[i].out;
            p1_oe[i]     <= pad_w[i].oe;
            p1_pullup[i] <= pad_w[i].pull;
            p1_hidrv[i]  <= pad_w[i].hidrv;
         end
         p07_pullup <= pull_q[pfs_pkg::PU_P07_BIT];
         p07_hidrv  <= drv0_q[pfs_pkg::DRV0_BIT];
      end
   end

   // input routing to peripherals, one cycle of latency
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         analog_en    <= 4'h0;
         uart0_rxd    <= 1'b1;
         uart0_clk_in <= 1'b0;
         timer_a_in   <= 1'b0;
         int1_in      <= 1'b0;
         cmp1_ref_en  <= 1'b0;
         key_in_en_q  <= 1'b0;
      end else begin
         analog_en    <= an_w;
         // rxd idles high when no pin feeds it
         uart0_rxd    <= (u0_rx && !dir_q[5]) ? p1_in[5] : 1'b1;
         uart0_clk_in <= ck_in ? p1_in[6] : 1'b0;
         if (!dir_q[5] && ta_p15 && (ta_inmode || lin_m))
            timer_a_in <= p1_in[5];
         else if (!dir_q[7] && ta_p17 && ta_inmode)
            timer_a_in <= p1_in[7];
         else
            timer_a_in <= 1'b0;
         if (i1_en && !i1_cp && !dir_q[5] && (i1_pin || lin_s))
            int1_in <= p1_in[5];
         else if (i1_en && !i1_cp && !dir_q[7] && !i1_pin)
            int1_in <= p1_in[7];
         else
            int1_in <= 1'b0;
         cmp1_ref_en  <= cmp_w;
         key_in_en_q  <= |(key_q[3:0] & ~dir_q[3:0]);
      end
   end

   // ---------------------------------------------------------------
   // read port: data stand one cycle after the strobe
   // ---------------------------------------------------------------
   assign stat_w = {2'h0, cmp_w, ck_out, tb_out, an_w[2:0]};
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && reg_addr[1:0] == 2'h0) begin
         unique case (reg_addr[5:2])
            pfs_pkg::IDX_DIR:    reg_rdata <= dir_q;
            pfs_pkg::IDX_KEY:    reg_rdata <= key_q;
            pfs_pkg::IDX_ADSEL:  reg_rdata <= adsel_q;
            pfs_pkg::IDX_TRC0:   reg_rdata <= trc0_q;
            pfs_pkg::IDX_TRC1:   reg_rdata <= trc1_q;
            pfs_pkg::IDX_U0SEL:  reg_rdata <= u0sel_q;
            pfs_pkg::IDX_U0MODE: reg_rdata <= u0mode_q;
            pfs_pkg::IDX_U0CTL:  reg_rdata <= u0ctl_q;
            pfs_pkg::IDX_TASEL:  reg_rdata <= tasel_q;
            pfs_pkg::IDX_TAMODE: reg_rdata <= tamode_q;
            pfs_pkg::IDX_INTCFG: reg_rdata <= intcfg_q;
            pfs_pkg::IDX_PULL:   reg_rdata <= pull_q;
            pfs_pkg::IDX_DRV0:   reg_rdata <= drv0_q;
            pfs_pkg::IDX_DRV1:   reg_rdata <= drv1_q;
            pfs_pkg::IDX_TBUSE:  reg_rdata <= tbuse_q;
            pfs_pkg::IDX_STAT:   reg_rdata <= stat_w;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   pull_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !tx_on |=> p1_pullup[0] == ($past(!dir_q[0]) && $past(pull_q[2])))
      else $error("low group pull-up wrong");
   pull_high_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!tx_on && !ck_out) |=> p1_pullup[6] == ($past(!dir_q[6]) && $past(pull_q[3])))
      else $error("high group pull-up wrong");
   p07_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      drv0_q[1] |=> p07_hidrv)
      else $error("port0 pin7 drive wrong");
   drive_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ##1 p1_hidrv == $past(drv1_q))
      else $error("port1 drive wrong");
   analog_p0_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (trc1_q[6:4] == 3'h1) |=> !analog_en[0])
      else $error("pin0 analog while timer c owns it");
   analog_p1_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!dir_q[1] && !key_q[1] && adsel_q[5:0] == 6'h11 && trc0_q[2:0] != 3'h1)
      |=> analog_en[1])
      else $error("pin1 analog missing");
   analog_p2_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      key_q[2] |=> !analog_en[2])
      else $error("pin2 analog with key input");
   tb_prio_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      tbuse_q[0] |=> p1_oe[3] && p1_out[3] == $past(timer_b_output))
      else $error("timer b lost pin3");
   open_drain_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (u0_tx && nch_f) |=> !(p1_oe[4] && p1_out[4]))
      else $error("open drain drove high");
   clk_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ck_out |=> p1_oe[6] && p1_out[6] == $past(uart0_clk_out))
      else $error("uart clock out missing");
   cmp_ref_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      u0_ck |=> !cmp1_ref_en)
      else $error("comparator ref with clock pin");
   ta_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ta_p17 && ta_pulse) |=> p1_oe[7] && p1_out[7] == $past(timer_a_pulse))
      else $error("timer a pulse missing");
   // routed inputs follow their pin one cycle later
   clk_in_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!dir_q[6] && u0_ck && clock_direction_bit_f) |=> uart0_clk_in == $past(p1_in[6]))
      else $error("uart clock in missing");
   ta_in_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!dir_q[5] && ta_p15 && ta_inmode) |=> timer_a_in == $past(p1_in[5]))
      else $error("timer a input missing");
   lin_master_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lin_m && !dir_q[5]) |=> uart0_rxd == $past(p1_in[5]) && timer_a_in == $past(p1_in[5]))
      else $error("lin master sharing missing");
   lin_slave_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lin_s && !dir_q[5]) |=> uart0_rxd == $past(p1_in[5]) && int1_in == $past(p1_in[5]))
      else $error("lin slave sharing missing");

endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic       sys_clk, resetn;                  // clock and reset
   logic [5:0] reg_addr;                         // byte address
   logic [7:0] reg_wdata, reg_rdata;             // register data
   logic       reg_wr, reg_rd;                   // access strobes
   logic [7:0] p1_in, p1_out, p1_oe, p1_pullup, p1_hidrv, p1_gpio_out;
   logic       p07_pullup, p07_hidrv, uart0_txd, uart0_clk_out, timer_a_pulse;
   logic       timer_b_output, timer_c_out_c, uart0_rxd, uart0_clk_in;
   logic       timer_a_in, int1_in, cmp1_ref_en, key_in_en_q;
   logic [3:0] analog_en;                        // analog connect per pin
   int         failures, compares;               // verdict counters
   logic [3:0] blk_i [4];                        // blocking timer c register
   logic [7:0] blk_v [4];                        // blocking timer c value

   pfs_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pullup),
      .p1_hidrv(p1_hidrv), .p07_pullup(p07_pullup), .p07_hidrv(p07_hidrv),
      .p1_gpio_out(p1_gpio_out), .uart0_txd(uart0_txd), .uart0_clk_out(uart0_clk_out),
      .timer_a_pulse(timer_a_pulse), .timer_b_output(timer_b_output),
      .timer_c_out_c(timer_c_out_c), .analog_en(analog_en), .uart0_rxd(uart0_rxd),
      .uart0_clk_in(uart0_clk_in), .timer_a_in(timer_a_in), .int1_in(int1_in),
      .cmp1_ref_en(cmp1_ref_en), .key_in_en_q(key_in_en_q));

   // ------------------------------------------------------------
   // clock, bus tasks and compare
   // ------------------------------------------------------------
   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;                 // 125 MHz

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // raw write, misaligned addresses allowed
   task automatic wra(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      wra({i, 2'h0}, d);
   endtask
   // read data stand only in the cycle after the taken edge
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask
   // outputs lag a write by two edges; three leave margin
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   // every setting back to zero so one row matches at a time
   task automatic clr();
      for (int i = 0; i < 15; i++) wr(4'(i), 8'h00);
      settle();
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog: the sequence needs well under 5000 cycles
   // ------------------------------------------------------------
   initial begin
      #100000;
      failures++;
      final_report();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {resetn, reg_addr, reg_wdata, reg_wr, reg_rd, p1_in, p1_gpio_out} = '0;
      {uart0_txd, uart0_clk_out, timer_a_pulse, timer_b_output, timer_c_out_c} = '0;
      failures = 0;
      compares = 0;
      blk_i = '{pfs_pkg::IDX_TRC1, pfs_pkg::IDX_TRC0, pfs_pkg::IDX_TRC0, pfs_pkg::IDX_TRC1};
      blk_v = '{8'h10, 8'h01, 8'h10, 8'h01};
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1 chk("reset_pads", 8'h80, {uart0_rxd, p1_oe[6:0] | p1_hidrv[6:0]});
      rd({pfs_pkg::IDX_DRV1, 2'h0}, 8'h00, "drv1_reset");
      // drive strength, misaligned access ignored
      wr(pfs_pkg::IDX_DRV1, 8'hA5);
      wr(pfs_pkg::IDX_DRV0, 8'h02);
      wr(pfs_pkg::IDX_PULL, 8'h02);
      wra(6'h35, 8'hFF);
      settle();
      chk("p1_hidrv", 8'hA5, p1_hidrv);
      chk("p07_attr", 8'h03, {6'h00, p07_hidrv, p07_pullup});
      rd({pfs_pkg::IDX_DRV1, 2'h0}, 8'hA5, "drv1_back");
      rd(6'h35, 8'h00, "misaligned_read");
      // pull-up groups only on input pins
      clr();
      wr(pfs_pkg::IDX_DIR, 8'h11);
      wr(pfs_pkg::IDX_PULL, 8'h04);
      settle();
      chk("pull_low", 8'h0E, p1_pullup);
      wr(pfs_pkg::IDX_PULL, 8'h08);
      settle();
      chk("pull_high", 8'hE0, p1_pullup);
      // plain output port
      wr(pfs_pkg::IDX_DIR, 8'hFF);
      p1_gpio_out <= 8'h5A;
      settle();
      chk("gpio_out", 8'h5A, p1_out & p1_oe);
      // analog per channel, then blocked by its timer c channel
      clr();
      for (int c = 0; c < 4; c++) begin
         wr(pfs_pkg::IDX_ADSEL, 8'h10 | 8'(c));
         settle();
         chk("analog_on", 8'h01 << c, 8'(analog_en));
         wr(blk_i[c], blk_v[c]);
         settle();
         chk("analog_blk", 8'h00, 8'(analog_en));
         wr(blk_i[c], 8'h00);
      end
      wr(pfs_pkg::IDX_ADSEL, 8'h10);
      wr(pfs_pkg::IDX_KEY, 8'h01);
      settle();
      chk("analog_key", 8'h01, {analog_en, 3'h0, key_in_en_q});
      // transmit open-drain versus push-pull
      clr();
      wr(pfs_pkg::IDX_U0SEL, 8'h01);
      wr(pfs_pkg::IDX_U0MODE, 8'h01);
      wr(pfs_pkg::IDX_U0CTL, 8'h20);
      settle();
      chk("txd_od_low", 8'h02, {6'h00, p1_oe[4], p1_out[4]});
      @(posedge sys_clk);
      uart0_txd <= 1'b1;
      settle();
      chk("txd_od_high", 8'h00, {6'h00, p1_oe[4], p1_out[4]});
      wr(pfs_pkg::IDX_U0CTL, 8'h00);
      settle();
      chk("txd_pp", 8'h03, {6'h00, p1_oe[4], p1_out[4]});
      // serial clock out, then external clock in
      clr();
      wr(pfs_pkg::IDX_U0SEL, 8'h10);
      wr(pfs_pkg::IDX_U0MODE, 8'h01);
      uart0_clk_out <= 1'b1;
      settle();
      chk("clk_out", 8'h03, {6'h00, p1_oe[6], p1_out[6]});
      wr(pfs_pkg::IDX_U0MODE, 8'h08);
      p1_in <= 8'h40;
      settle();
      chk("clk_in", 8'h01, 8'(uart0_clk_in));
      // comparator reference needs clock pin select clear
      wr(pfs_pkg::IDX_INTCFG, 8'h04);
      settle();
      chk("cmp_blk", 8'h00, 8'(cmp1_ref_en));
      wr(pfs_pkg::IDX_U0SEL, 8'h00);
      settle();
      chk("cmp_ref", 8'h01, 8'(cmp1_ref_en));
      // timer a pulse output on both selectable pins
      clr();
      wr(pfs_pkg::IDX_TAMODE, 8'h01);
      timer_a_pulse <= 1'b1;
      wr(pfs_pkg::IDX_TASEL, 8'h02);
      settle();
      chk("pulse_p5", 8'h20, p1_oe & p1_out & 8'hA0);
      wr(pfs_pkg::IDX_TASEL, 8'h01);
      settle();
      chk("pulse_p7", 8'h80, p1_oe & p1_out & 8'hA0);
      // timer a input, and none in pulse mode
      clr();
      wr(pfs_pkg::IDX_TASEL, 8'h02);
      p1_in <= 8'h20;
      wr(pfs_pkg::IDX_TAMODE, 8'h02);
      settle();
      chk("ta_in", 8'h01, 8'(timer_a_in));
      wr(pfs_pkg::IDX_TAMODE, 8'h01);
      settle();
      chk("ta_in_pulse", 8'h00, 8'(timer_a_in));
      // lin master then slave sharing pin 5
      wr(pfs_pkg::IDX_U0SEL, 8'h04);
      wr(pfs_pkg::IDX_TAMODE, 8'h00);
      settle();
      chk("lin_m_hi", 8'h06, {5'h00, uart0_rxd, timer_a_in, int1_in});
      wr(pfs_pkg::IDX_TAMODE, 8'h03);
      wr(pfs_pkg::IDX_INTCFG, 8'h03);
      settle();
      chk("lin_s_hi", 8'h07, {5'h00, uart0_rxd, timer_a_in, int1_in});
      @(posedge sys_clk);
      p1_in <= 8'h00;
      settle();
      chk("lin_s_lo", 8'h00, {5'h00, uart0_rxd, timer_a_in, int1_in});
      // timer b output wins pin 3 over timer c
      clr();
      wr(pfs_pkg::IDX_DIR, 8'h08);
      wr(pfs_pkg::IDX_TRC1, 8'h01);
      wr(pfs_pkg::IDX_TBUSE, 8'h01);
      timer_b_output <= 1'b1;
      settle();
      chk("pin3_tb_hi", 8'h01, 8'(p1_out[3]));
      @(posedge sys_clk);
      timer_b_output <= 1'b0;
      timer_c_out_c  <= 1'b1;
      settle();
      chk("pin3_tb_lo", 8'h00, 8'(p1_out[3]));
      wr(pfs_pkg::IDX_TBUSE, 8'h00);
      settle();
      chk("pin3_tc", 8'h01, 8'(p1_out[3]));
      final_report();
   end
endmodule
